// ==== shared/mfs_pkg.sv ====
// Constants, register map and carrier types of the motor fault supervisor.
package mfs_pkg;

  localparam int MFS_AW = 8;
  localparam int MFS_DW = 32;
  localparam int MFS_TW = 16;
  localparam int MFS_NFLT = 6;

  localparam logic [MFS_AW-1:0] MFS_OFS_CLEAR = 8'h00;
  localparam logic [MFS_AW-1:0] MFS_OFS_ENABLE = 8'h04;
  localparam logic [MFS_AW-1:0] MFS_OFS_LIVE = 8'h08;
  localparam logic [MFS_AW-1:0] MFS_OFS_LATCHED = 8'h0c;
  localparam logic [MFS_AW-1:0] MFS_OFS_I_MAX = 8'h10;
  localparam logic [MFS_AW-1:0] MFS_OFS_U_LOW = 8'h14;
  localparam logic [MFS_AW-1:0] MFS_OFS_U_HIGH = 8'h18;
  localparam logic [MFS_AW-1:0] MFS_OFS_N_OVER = 8'h1c;
  localparam logic [MFS_AW-1:0] MFS_OFS_E_BLOCK = 8'h20;
  localparam logic [MFS_AW-1:0] MFS_OFS_E_PERSIST = 8'h24;
  localparam logic [MFS_AW-1:0] MFS_OFS_FLAG0 = 8'h40;
  localparam logic [MFS_AW-1:0] MFS_OFS_FLAG_LAST = 8'h54;

  localparam int MFS_FLT_OC = 0;
  localparam int MFS_FLT_UV = 1;
  localparam int MFS_FLT_OV = 2;
  localparam int MFS_FLT_OL = 3;
  localparam int MFS_FLT_OS = 4;
  localparam int MFS_FLT_BR = 5;

  localparam int MFS_CLEAR_BIT = 0;
  localparam logic [7:0] MFS_ENABLE_RST = 8'h3e;
  localparam logic [7:0] MFS_ENABLE_WMASK = 8'h3e;
  localparam logic [7:0] MFS_ENABLE_FIXED = 8'h01;
  localparam logic [7:0] MFS_VEC_RST = 8'h00;
  localparam logic [MFS_TW-1:0] MFS_I_MAX_RST = 16'hffff;
  localparam logic [MFS_TW-1:0] MFS_U_LOW_RST = 16'h0000;
  localparam logic [MFS_TW-1:0] MFS_U_HIGH_RST = 16'hffff;
  localparam logic [MFS_TW-1:0] MFS_N_OVER_RST = 16'hffff;
  localparam logic [MFS_TW-1:0] MFS_E_BLOCK_RST = 16'h0000;
  localparam logic [MFS_TW-1:0] MFS_E_PERSIST_RST = 16'h0064;

  typedef struct packed {
    logic [MFS_TW-1:0] bus_current;
    logic [MFS_TW-1:0] bus_voltage;
    logic [MFS_TW-1:0] rotor_speed;
    logic [MFS_TW-1:0] bemf_level;
    logic overload;
  } mfs_meas_t;

  typedef struct packed {
    logic [MFS_TW-1:0] current_max;
    logic [MFS_TW-1:0] bus_low_voltage_threshold;
    logic [MFS_TW-1:0] bus_high_voltage_threshold;
    logic [MFS_TW-1:0] speed_over;
    logic [MFS_TW-1:0] bemf_block;
    logic [MFS_TW-1:0] bemf_persist;
  } mfs_thr_t;

endpackage : mfs_pkg

// ==== rtl/mfs_block_timer.sv ====
// Persistence timer that qualifies the blocked-rotor condition.
`timescale 1ns/1ps
module mfs_block_timer
  import mfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_stb,
  input wire logic bemf_low,
  input wire logic [MFS_TW-1:0] persist,
  output logic blocked
);

  logic [MFS_TW-1:0] cnt_r;
  logic [MFS_TW-1:0] cnt_nxt;
  logic blocked_r;
  logic blocked_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    blocked_nxt = blocked_r;
    if (sample_stb) begin
      if (!bemf_low) begin
        cnt_nxt = '0;
      end else if (cnt_r != {MFS_TW{1'b1}}) begin
        cnt_nxt = cnt_r + 16'h0001;
      end
      blocked_nxt = bemf_low && (cnt_nxt > persist);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      blocked_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      blocked_r <= blocked_nxt;
    end
  end

  assign blocked = blocked_r;

endmodule : mfs_block_timer

// ==== rtl/mfs_supervisor.sv ====
// Motor fault supervisor with APB register access.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
// Functional notes
// - Live bit 0 set while bus current exceeds programmed maximum.
// - Overcurrent forces PWM outputs off with no software step.
// - Live bit 1 set while bus voltage is below low threshold.
// - Live bit 2 set while bus voltage is above high threshold.
// - Live bit 3 set while the overload input is high.
// - Live bit 4 set while rotor speed exceeds overspeed threshold.
// - Live bit 5 set when back-EMF stays low longer than persistence.
// - Live bits follow present conditions and clear themselves.
// - Each fault sets its latched bit, which stays after the cause ends.
// - Each of the six faults has its own readable latched flag.
// - Writing one to the clear control clears latched bits whose live bit is clear; reads no request.
// - Writing zero to enable bits 1-5 suppresses that fault; all enabled at reset.
// - Overcurrent cannot be masked by any enable.
// - Any indicated fault requests the drive FAULT state.
module mfs_supervisor
  import mfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [MFS_AW-1:0] paddr,
  input wire logic [MFS_DW-1:0] pwdata,
  output logic [MFS_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_stb,
  input wire mfs_meas_t meas,
  output logic pwm_disable,
  output logic fault_state_req,
  output logic [7:0] live_fault_vector,
  output logic [7:0] latched_fault_vector
);

  // Register bus group.
  logic [MFS_DW-1:0] prdata_r;
  logic [MFS_DW-1:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  // Configuration group.
  logic [7:0] fault_type_mask_enable_r;
  logic [7:0] fault_type_mask_enable_nxt;
  mfs_thr_t thr_r;
  mfs_thr_t thr_nxt;

  // Fault state group.
  logic [7:0] live_r;
  logic [7:0] live_nxt;
  logic [7:0] latched_r;
  logic [7:0] latched_nxt;
  logic pwm_disable_r;
  logic pwm_disable_nxt;
  logic fault_req_r;
  logic fault_req_nxt;

  logic blocked;
  logic wr_take;
  logic latched_fault_clear_req;
  logic [7:0] raw;

  function automatic logic addr_known(input logic [MFS_AW-1:0] a);
    logic ok;
    ok = 1'b0;
    case (a)
      MFS_OFS_CLEAR, MFS_OFS_ENABLE, MFS_OFS_LIVE, MFS_OFS_LATCHED,
      MFS_OFS_I_MAX, MFS_OFS_U_LOW, MFS_OFS_U_HIGH, MFS_OFS_N_OVER,
      MFS_OFS_E_BLOCK, MFS_OFS_E_PERSIST: ok = 1'b1;
      default: ok = (a >= MFS_OFS_FLAG0) && (a <= MFS_OFS_FLAG_LAST) && (a[1:0] == 2'b00);
    endcase
    return ok;
  endfunction : addr_known

  function automatic logic [MFS_DW-1:0] wide16(input logic [MFS_TW-1:0] v);
    return {{(MFS_DW-MFS_TW){1'b0}}, v};
  endfunction : wide16

  mfs_block_timer u_block_timer (
    .pclk(pclk),
    .presetn(presetn),
    .sample_stb(sample_stb),
    .bemf_low(meas.bemf_level < thr_r.bemf_block),
    .persist(thr_r.bemf_persist),
    .blocked(blocked)
  );

  // A write takes effect only at the completing access edge.
  assign wr_take = psel && penable && pready_r && pwrite && !pslverr_r;
  assign latched_fault_clear_req = wr_take && (paddr == MFS_OFS_CLEAR) && pwdata[MFS_CLEAR_BIT];

  // Read data and answer are prepared in the setup cycle, so each access has no wait state.
  always_comb begin
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !addr_known(paddr);
      prdata_nxt = '0;
      if (!pwrite) begin
        case (paddr)
          MFS_OFS_CLEAR: prdata_nxt = '0;
          MFS_OFS_ENABLE: prdata_nxt = {24'h000000, fault_type_mask_enable_r};
          MFS_OFS_LIVE: prdata_nxt = {24'h000000, live_r};
          MFS_OFS_LATCHED: prdata_nxt = {24'h000000, latched_r};
          MFS_OFS_I_MAX: prdata_nxt = wide16(thr_r.current_max);
          MFS_OFS_U_LOW: prdata_nxt = wide16(thr_r.bus_low_voltage_threshold);
          MFS_OFS_U_HIGH: prdata_nxt = wide16(thr_r.bus_high_voltage_threshold);
          MFS_OFS_N_OVER: prdata_nxt = wide16(thr_r.speed_over);
          MFS_OFS_E_BLOCK: prdata_nxt = wide16(thr_r.bemf_block);
          MFS_OFS_E_PERSIST: prdata_nxt = wide16(thr_r.bemf_persist);
          default: begin
            if (addr_known(paddr)) begin
              prdata_nxt = {31'h00000000, latched_r[3'(paddr[4:2] - 3'd0)]};
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Software-written configuration: enables and thresholds.
  always_comb begin
    fault_type_mask_enable_nxt = fault_type_mask_enable_r;
    thr_nxt = thr_r;
    if (wr_take) begin
      case (paddr)
        MFS_OFS_ENABLE: begin
          fault_type_mask_enable_nxt = (pwdata[7:0] & MFS_ENABLE_WMASK) | MFS_ENABLE_FIXED;
        end
        MFS_OFS_I_MAX: thr_nxt.current_max = pwdata[MFS_TW-1:0];
        MFS_OFS_U_LOW: thr_nxt.bus_low_voltage_threshold = pwdata[MFS_TW-1:0];
        MFS_OFS_U_HIGH: thr_nxt.bus_high_voltage_threshold = pwdata[MFS_TW-1:0];
        MFS_OFS_N_OVER: thr_nxt.speed_over = pwdata[MFS_TW-1:0];
        MFS_OFS_E_BLOCK: thr_nxt.bemf_block = pwdata[MFS_TW-1:0];
        MFS_OFS_E_PERSIST: thr_nxt.bemf_persist = pwdata[MFS_TW-1:0];
        default: thr_nxt = thr_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_type_mask_enable_r <= MFS_ENABLE_RST | MFS_ENABLE_FIXED;
      thr_r.current_max <= MFS_I_MAX_RST;
      thr_r.bus_low_voltage_threshold <= MFS_U_LOW_RST;
      thr_r.bus_high_voltage_threshold <= MFS_U_HIGH_RST;
      thr_r.speed_over <= MFS_N_OVER_RST;
      thr_r.bemf_block <= MFS_E_BLOCK_RST;
      thr_r.bemf_persist <= MFS_E_PERSIST_RST;
    end else begin
      fault_type_mask_enable_r <= fault_type_mask_enable_nxt;
      thr_r <= thr_nxt;
    end
  end

  // Raw fault conditions: bits 0-4 from the present sample, bit 5 from the registered block timer output.
  always_comb begin
    raw = 8'h00;
    raw[MFS_FLT_OC] = meas.bus_current > thr_r.current_max;
    raw[MFS_FLT_UV] = meas.bus_voltage < thr_r.bus_low_voltage_threshold;
    raw[MFS_FLT_OV] = meas.bus_voltage > thr_r.bus_high_voltage_threshold;
    raw[MFS_FLT_OL] = meas.overload;
    raw[MFS_FLT_OS] = meas.rotor_speed > thr_r.speed_over;
    raw[MFS_FLT_BR] = blocked;
  end

  // Live vector follows the sample; latched vector keeps every fault until cleared.
  always_comb begin
    live_nxt = live_r;
    if (sample_stb) begin
      live_nxt = raw & (fault_type_mask_enable_r | MFS_ENABLE_FIXED);
    end
    live_nxt[7:6] = 2'b00;
    latched_nxt = latched_fault_clear_req ? MFS_VEC_RST : latched_r;
    latched_nxt = latched_nxt | live_nxt;
    pwm_disable_nxt = live_nxt[MFS_FLT_OC];
    fault_req_nxt = |latched_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_r <= MFS_VEC_RST;
      latched_r <= MFS_VEC_RST;
      pwm_disable_r <= 1'b0;
      fault_req_r <= 1'b0;
    end else begin
      live_r <= live_nxt;
      latched_r <= latched_nxt;
      pwm_disable_r <= pwm_disable_nxt;
      fault_req_r <= fault_req_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pwm_disable = pwm_disable_r;
  assign fault_state_req = fault_req_r;
  assign live_fault_vector = live_r;
  assign latched_fault_vector = latched_r;

endmodule : mfs_supervisor

// ==== tb/mfs_props.sv ====
// Concurrent checks on the ports of the motor fault supervisor.
`timescale 1ns/1ps
module mfs_props
  import mfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [MFS_AW-1:0] paddr,
  input wire logic [MFS_DW-1:0] pwdata,
  input wire logic sample_stb,
  input wire mfs_meas_t meas,
  input wire logic pwm_disable,
  input wire logic fault_state_req,
  input wire logic [7:0] live_fault_vector,
  input wire logic [7:0] latched_fault_vector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pwm_follow_a: assert property (
    pwm_disable == live_fault_vector[0]) else $error("pwm disable differs from live bit 0");
  upper_zero_a: assert property (
    live_fault_vector[7:6] == 2'h0 && latched_fault_vector[7:6] == 2'h0) else $error("upper bits set");
  live_kept_a: assert property (
    (live_fault_vector & ~latched_fault_vector) == 8'h00) else $error("live fault not latched");
  fault_req_a: assert property (
    fault_state_req == (latched_fault_vector != 8'h00)) else $error("fault request wrong");
  live_hold_a: assert property (
    !sample_stb |=> $stable(live_fault_vector)) else $error("live changed without strobe");
  latch_rise_a: assert property (
    (latched_fault_vector & ~$past(latched_fault_vector)) != 8'h00 |-> $past(sample_stb))
    else $error("latched bit set without strobe");
  latch_fall_a: assert property (
    (~latched_fault_vector & $past(latched_fault_vector)) != 8'h00
    |-> $past(psel && penable && pwrite && paddr == MFS_OFS_CLEAR && pwdata[0]))
    else $error("latched bit lost without clear");
  overload_off_a: assert property (
    sample_stb && !meas.overload |=> !live_fault_vector[3]) else $error("overload bit stuck");
  low_volt_top_a: assert property (
    sample_stb && meas.bus_voltage == 16'hffff |=> !live_fault_vector[1])
    else $error("undervoltage at full-scale voltage");
endmodule : mfs_props

// ==== tb/tb.sv ====
// Self-checking bench for the motor fault supervisor.
`timescale 1ns/1ps
module tb import mfs_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [MFS_AW-1:0] paddr = 8'h00;
  logic [MFS_DW-1:0] pwdata = 32'h0;
  logic [MFS_DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_stb = 1'b0;
  mfs_meas_t meas = '0;
  mfs_meas_t m;
  logic pwm_disable;
  logic fault_state_req;
  logic [7:0] live_fault_vector;
  logic [7:0] latched_fault_vector;
  logic [7:0] lat;
  logic [7:0] x;
  logic [31:0] q;
  logic e;
  int error_cnt = 0;
  int n_compared = 0;
  always #12.5 pclk = ~pclk;
  mfs_supervisor uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_stb(sample_stb), .meas(meas), .pwm_disable(pwm_disable), .fault_state_req(fault_state_req),
    .live_fault_vector(live_fault_vector), .latched_fault_vector(latched_fault_vector));
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic strobe(input mfs_meas_t mm);
    @(posedge pclk);
    meas <= mm;
    sample_stb <= 1'b1;
    @(posedge pclk);
    sample_stb <= 1'b0;
    @(negedge pclk);
  endtask : strobe
  function automatic logic [7:0] ex_live(input mfs_meas_t mm, input logic [7:0] en);
    return {3'h0, mm.rotor_speed > 16'h01f4, mm.overload, mm.bus_voltage > 16'h0384,
      mm.bus_voltage < 16'h0064, mm.bus_current > 16'h03e8} & en;
  endfunction : ex_live
  initial begin
    q = $urandom(32'h3bbb);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, MFS_OFS_ENABLE, 32'h0);
    chk("enable", 32'h3f, q);
    chk("slverr_ok", 32'h0, e);
    apb(1'b0, MFS_OFS_E_PERSIST, 32'h0);
    chk("persist", 32'h64, q);
    apb(1'b0, 8'h30, 32'h0);
    chk("slverr", 32'h1, e);
    apb(1'b1, MFS_OFS_I_MAX, 32'h3e8);
    apb(1'b1, MFS_OFS_U_LOW, 32'h64);
    apb(1'b1, MFS_OFS_U_HIGH, 32'h384);
    apb(1'b1, MFS_OFS_N_OVER, 32'h1f4);
    apb(1'b1, MFS_OFS_E_BLOCK, 32'h32);
    apb(1'b1, MFS_OFS_E_PERSIST, 32'h3);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, MFS_OFS_ENABLE, p ? 32'h0 : 32'h3f);
      lat = 8'h00;
      for (int i = 0; i < 40; i++) begin
        m.bus_current = 16'($urandom_range(1100, 900));
        m.bus_voltage = 16'($urandom_range(1000, 0));
        m.rotor_speed = 16'($urandom_range(600, 400));
        m.bemf_level = 16'($urandom_range(200, 50));
        m.overload = 1'($urandom_range(1, 0));
        strobe(m);
        x = ex_live(m, p ? 8'h01 : 8'h3f);
        lat |= x;
        chk("live", x, live_fault_vector);
        chk("latched", lat, latched_fault_vector);
        chk("pwm", x[0], pwm_disable);
        chk("fault_req", |lat, fault_state_req);
      end
      m = '{16'h0000, 16'h0200, 16'h0000, 16'h0100, 1'b0};
      strobe(m);
      chk("live_idle", 32'h0, live_fault_vector);
      for (int f = 0; f < 6; f++) begin
        apb(1'b0, 8'h40 + 8'(4 * f), 32'h0);
        chk("flag", lat[f], q);
      end
      apb(1'b1, MFS_OFS_CLEAR, 32'h1);
      @(negedge pclk);
      chk("cleared", 32'h0, latched_fault_vector);
      apb(1'b0, MFS_OFS_CLEAR, 32'h0);
      chk("clear_read", 32'h0, q);
    end
    apb(1'b1, MFS_OFS_ENABLE, 32'h3f);
    m.bus_voltage = 16'h0010;
    strobe(m);
    apb(1'b1, MFS_OFS_CLEAR, 32'h1);
    @(negedge pclk);
    chk("clear_hold", 32'h02, latched_fault_vector);
    apb(1'b1, MFS_OFS_LATCHED, 32'hff);
    apb(1'b0, MFS_OFS_LATCHED, 32'h0);
    chk("latched_rd", 32'h02, q);
    m.bus_voltage = 16'h0200;
    m.bemf_level = 16'h0010;
    for (int i = 1; i <= 5; i++) begin
      strobe(m);
      chk("blocked", i == 5, live_fault_vector[5]);
    end
    m.bemf_level = 16'h0100;
    strobe(m);
    chk("blocked_lag", 32'h1, live_fault_vector[5]);
    strobe(m);
    chk("blocked_end", 32'h0, live_fault_vector[5]);
    m.bus_voltage = 16'hffff;
    strobe(m);
    chk("uv_top", 32'h0, live_fault_vector[1]);
    chk("ov_top", 32'h1, live_fault_vector[2]);
    complete_run();
  end
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end
endmodule : tb
bind mfs_supervisor mfs_props chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sample_stb(sample_stb), .meas(meas),
  .pwm_disable(pwm_disable), .fault_state_req(fault_state_req), .live_fault_vector(live_fault_vector),
  .latched_fault_vector(latched_fault_vector));
